// file: src/guard_params.svh
// Constants for the serial memory access guard.
`ifndef GUARD_PARAMS_SVH
`define GUARD_PARAMS_SVH

`define CLK_HZ 64'd200000000
`define ACC_TIMEOUT_MS 64'd500
`define ACC_CYCLES_CALC ((`ACC_TIMEOUT_MS * `CLK_HZ) / 64'd1000)

`define CRC_INIT 3'h7
`define READ_LEN 6'h13
`define WRITE_LEN 6'h33
`define ACK_SYNC_LAST 6'h01
`define ACK_DATA_LAST 6'h21
`define ACK_CRC_LAST 6'h24
`define ACK_END 6'h25

`define HDR_RW 13
`define HDR_FS_MSB 8
`define HDR_FS_LSB 7
`define HDR_ADDR_MSB 6

`define SHADOW_LAST 7'h3F
`define FACTORY_LAST 7'h07
`define CFG_ADDR 7'h1E
`define ADDR_MARG_DATA 7'h41
`define ADDR_MARG_STATUS 7'h42
`define ADDR_MARG_CTRL 7'h43

`define CODE_ADDR 8'h79
`define CODE_DATA 32'hC41D3432

`define LOCK_EE_RO 3'h3
`define LOCK_ALL_RO 3'h6
`define LOCK_SEALED 3'h5

`define CTRL_START 0
`define CTRL_MODE_MSB 2
`define CTRL_MODE_LSB 1
`define MODE_ONES 2'h1
`define MODE_ZEROS 2'h2
`define EE_WORDS_LAST 5'h1F

`endif

// file: src/guard_pkg.sv
// Types and shared functions for the serial memory access guard.
package guard_pkg;
    typedef enum logic [1:0] {
        FS_WORD = 2'b00,
        FS_LOW = 2'b01,
        FS_HIGH = 2'b10,
        FS_NONE = 2'b11
    } field_sel_t;

    typedef enum logic [1:0] {
        LS_IDLE = 2'b00,
        LS_RX = 2'b01,
        LS_TX = 2'b10
    } link_state_t;

    typedef enum logic [1:0] {
        MS_IDLE = 2'b00,
        MS_RUN = 2'b01
    } margin_state_t;

    function automatic logic [2:0] crc_step(input logic [2:0] c,
                                            input logic b);
        logic fb;
        fb = c[2] ^ b;
        crc_step = {c[1], c[0] ^ fb, fb};
    endfunction
endpackage

// file: src/link_frame_port.sv
// Link-clock side: frame receiver, CRC check and acknowledge sender.
`timescale 1ns/1ps
`include "guard_params.svh"
module link_frame_port (
    input wire logic link_clk,
    input wire logic nrst,
    input wire logic link_frame,
    input wire logic link_din,
    output logic link_dout,
    output logic link_doe,
    output logic [13:0] rx_hdr,
    output logic [31:0] rx_data,
    output logic rx_crc_ok,
    output logic rx_tgl,
    input wire logic [31:0] ack_data,
    input wire logic ack_tgl,
    output guard_pkg::link_state_t link_state
);
    import guard_pkg::*;

    logic rst_meta_q, rst_n_q;
    logic ack_s1_q, ack_s2_q, ack_s3_q, ack_seen_q;
    logic ack_pend;
    link_state_t state_q;
    logic [5:0] cnt_q;
    logic rw_q;
    logic [47:0] sh_q;
    logic [2:0] crc_q;
    logic [48:0] full;
    logic [5:0] last_idx;
    logic [31:0] tx_sh_q;
    logic [2:0] tx_crc_q;

    assign link_state = state_q;
    // A new acknowledge is pending once the toggle has settled.
    assign ack_pend = (ack_s2_q == ack_s3_q) && (ack_s3_q != ack_seen_q);
    assign full = {sh_q, link_din};
    assign last_idx = rw_q ? `READ_LEN - 6'h01 : `WRITE_LEN - 6'h01;

    // Reset reaches this domain only while the link clock runs.
    always_ff @(posedge link_clk)
    begin
        rst_meta_q <= nrst;
        rst_n_q <= rst_meta_q;
    end

    always_ff @(posedge link_clk)
    begin
        ack_s1_q <= ack_tgl;
        ack_s2_q <= ack_s1_q;
        ack_s3_q <= ack_s2_q;
    end

    always_ff @(posedge link_clk)
    begin
        if (!rst_n_q || !link_frame)
        begin
            state_q <= LS_IDLE;
            cnt_q <= 6'h00;
        end
        else
        begin
            case (state_q)
                LS_IDLE:
                begin
                    cnt_q <= 6'h01;
                    state_q <= ack_pend ? LS_TX : LS_RX;
                end
                LS_RX:
                begin
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q > 6'h02 && cnt_q == last_idx)
                        state_q <= LS_IDLE;
                end
                LS_TX:
                begin
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q == `ACK_END)
                        state_q <= LS_IDLE;
                end
                default: state_q <= LS_IDLE;
            endcase
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (!rst_n_q)
        begin
            sh_q <= 48'h000000000000;
            crc_q <= `CRC_INIT;
            rw_q <= 1'b0;
            rx_hdr <= 14'h0000;
            rx_data <= 32'h00000000;
            rx_crc_ok <= 1'b0;
            rx_tgl <= 1'b0;
        end
        else if (state_q != LS_RX || !link_frame)
        begin
            crc_q <= `CRC_INIT;
            sh_q <= 48'h000000000000;
        end
        else
        begin
            sh_q <= full[47:0];
            if (cnt_q == 6'h02)
                rw_q <= link_din;
            // Sync bits at index 0 and 1 never enter the CRC.
            if (cnt_q >= 6'h02 && cnt_q < last_idx - 6'h02)
                crc_q <= crc_step(crc_q, link_din);
            if (cnt_q > 6'h02 && cnt_q == last_idx)
            begin
                rx_crc_ok <= (full[2:0] == crc_q);
                if (rw_q)
                begin
                    rx_hdr <= full[16:3];
                    rx_data <= 32'h00000000;
                end
                else
                begin
                    rx_hdr <= full[48:35];
                    rx_data <= full[34:3];
                end
                rx_tgl <= ~rx_tgl;
            end
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (!rst_n_q)
        begin
            ack_seen_q <= 1'b0;
            tx_sh_q <= 32'h00000000;
            tx_crc_q <= `CRC_INIT;
            link_dout <= 1'b0;
            link_doe <= 1'b0;
        end
        else if (!link_frame)
            link_doe <= 1'b0;
        else if (state_q == LS_IDLE && ack_pend)
        begin
            ack_seen_q <= ack_s3_q;
            tx_sh_q <= ack_data;
            tx_crc_q <= `CRC_INIT;
            link_dout <= 1'b0;
            link_doe <= 1'b1;
        end
        else if (state_q == LS_TX)
        begin
            if (cnt_q <= `ACK_SYNC_LAST)
                link_dout <= 1'b0;
            else if (cnt_q <= `ACK_DATA_LAST)
            begin
                link_dout <= tx_sh_q[31];
                tx_sh_q <= {tx_sh_q[30:0], 1'b0};
                tx_crc_q <= crc_step(tx_crc_q, tx_sh_q[31]);
            end
            else if (cnt_q <= `ACK_CRC_LAST)
            begin
                link_dout <= tx_crc_q[2];
                tx_crc_q <= {tx_crc_q[1:0], 1'b0};
            end
            else
                link_doe <= 1'b0;
        end
    end
endmodule // link_frame_port

// file: src/serial_memory_access_guard.sv
// Memory access guard behind the single-pin serial programming link.
// Overview of operation
// - Field select picks bits 11:0 or 25:12 of the addressed word.
// - Frame CRC covers all bits except the two leading sync bits and the CRC token.
// - CRC polynomial is x^3 + x + 1.
// - Each frame ends with a three-bit CRC token.
// - CRC register starts at 111 for every frame.
// - Customer writes need the unlock code within 500 ms of reset.
// - After customer unlock, factory registers read but never write.
// - Lock values 0, 1, 2, 4, 7 give full access.
// - Lock 3 blocks EEPROM writes, allows volatile writes and reads.
// - Lock 6 blocks all writes, allows all reads.
// - Lock 5 refuses all reads and writes.
// - Margin test needs customer access; checks ones, zeros or both.
// - Writing the start bit at 0x43 runs the margin check.
// - Margin results are read back at 0x41 and 0x42.
// - A margin failure only shows in the result registers.
// - Addresses: EEPROM 0x00-0x1F, shadow 0x20-0x3F, volatile 0x40-0x7F.
// - Field select 0 whole word, 1 low, 2 high, 3 unused.
// - Data field holds 26 data bits and 6 ECC bits.
// - Link bits are Manchester coded; decoding sits outside this block.
`timescale 1ns/1ps
`include "guard_params.svh"
module serial_memory_access_guard #(
    parameter logic [31:0] ACC_CYCLES = 32'(`ACC_CYCLES_CALC)
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic link_clk,
    input wire logic link_frame,
    input wire logic link_din,
    output logic link_dout,
    output logic link_doe,
    output logic [4:0] margin_addr,
    input wire logic [31:0] margin_weak,
    output logic customer_access,
    output guard_pkg::margin_state_t margin_state
);
    import guard_pkg::*;

    logic [13:0] rx_hdr;
    logic [31:0] rx_data;
    logic rx_crc_ok, rx_tgl;
    logic rx_s1_q, rx_s2_q, rx_s3_q, rx_seen_q;
    logic rx_evt;
    logic [31:0] ack_data_q;
    logic ack_tgl_q;
    logic [31:0] mem_q [0:127];
    logic [31:0] win_q;
    logic win_open;
    logic customer_q;
    logic rw;
    field_sel_t fs;
    logic [6:0] addr;
    logic [2:0] lock;
    logic is_code, do_wr, do_rd;
    logic [31:0] cur_word, new_word;
    logic [2:0] ctrl_q;
    margin_state_t mstate_q;
    logic [4:0] ptr_q;
    logic done_q, fail_q;
    logic [4:0] first_addr_q;
    logic [5:0] fail_cnt_q;
    logic [25:0] mdata_q;
    logic chk_ones, chk_zeros, word_bad;
    logic [31:0] status_word;

    link_frame_port u_link (
        .link_clk(link_clk),
        .nrst(nrst),
        .link_frame(link_frame),
        .link_din(link_din),
        .link_dout(link_dout),
        .link_doe(link_doe),
        .rx_hdr(rx_hdr),
        .rx_data(rx_data),
        .rx_crc_ok(rx_crc_ok),
        .rx_tgl(rx_tgl),
        .ack_data(ack_data_q),
        .ack_tgl(ack_tgl_q),
        .link_state()
    );

    function automatic logic [31:0] merge_field(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input field_sel_t f);
        case (f)
            FS_LOW: merge_field = {old_w[31:12], new_w[11:0]};
            FS_HIGH: merge_field = {old_w[31:26], new_w[25:12], old_w[11:0]};
            default: merge_field = new_w;
        endcase
    endfunction

    function automatic logic [31:0] mask_field(input logic [31:0] w,
                                               input field_sel_t f);
        case (f)
            FS_LOW: mask_field = {20'h00000, w[11:0]};
            FS_HIGH: mask_field = {6'h00, w[25:12], 12'h000};
            default: mask_field = w;
        endcase
    endfunction

    function automatic logic write_allowed(input logic [6:0] a,
                                           input logic [2:0] lk,
                                           input logic cust);
        if (!cust)
            write_allowed = 1'b0;
        else if (lk == `LOCK_SEALED || lk == `LOCK_ALL_RO)
            write_allowed = 1'b0;
        else if (a <= `FACTORY_LAST)
            write_allowed = 1'b0;
        else if (a == `ADDR_MARG_DATA || a == `ADDR_MARG_STATUS)
            write_allowed = 1'b0;
        else if (lk == `LOCK_EE_RO && a <= `SHADOW_LAST)
            write_allowed = 1'b0;
        else
            write_allowed = 1'b1;
    endfunction

    // Header and data are read only after the toggle settles.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rx_s1_q <= 1'b0;
            rx_s2_q <= 1'b0;
            rx_s3_q <= 1'b0;
            rx_seen_q <= 1'b0;
        end
        else
        begin
            rx_s1_q <= rx_tgl;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
            if (rx_s2_q == rx_s3_q)
                rx_seen_q <= rx_s3_q;
        end
    end

    assign rx_evt = (rx_s2_q == rx_s3_q) && (rx_s3_q != rx_seen_q);
    assign rw = rx_hdr[`HDR_RW];
    assign fs = field_sel_t'(rx_hdr[`HDR_FS_MSB:`HDR_FS_LSB]);
    assign addr = rx_hdr[`HDR_ADDR_MSB:0];
    assign lock = mem_q[`CFG_ADDR][2:0];
    assign win_open = win_q < ACC_CYCLES;
    assign is_code = !rw && {rx_hdr[`HDR_FS_LSB], addr} == `CODE_ADDR
        && rx_data == `CODE_DATA;
    assign do_wr = rx_evt && rx_crc_ok && !rw && !is_code && fs != FS_NONE
        && write_allowed(addr, lock, customer_q);
    assign do_rd = rx_evt && rx_crc_ok && rw && fs != FS_NONE
        && lock != `LOCK_SEALED;
    assign status_word = {18'h00000, fail_cnt_q, first_addr_q, fail_q,
        done_q, mstate_q == MS_RUN};

    always_comb
    begin
        case (addr)
            `ADDR_MARG_DATA: cur_word = {6'h00, mdata_q};
            `ADDR_MARG_STATUS: cur_word = status_word;
            `ADDR_MARG_CTRL: cur_word = {29'h00000000, ctrl_q};
            default: cur_word = mem_q[addr];
        endcase
        new_word = merge_field(cur_word, rx_data, fs);
    end

    // The window counter stops at its limit so it never wraps open again.
    always_ff @(posedge clk)
    begin
        if (!nrst)
            win_q <= 32'h00000000;
        else if (win_open)
            win_q <= win_q + 32'h00000001;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            customer_q <= 1'b0;
        else if (rx_evt && rx_crc_ok && is_code && win_open)
            customer_q <= 1'b1;
    end

    assign customer_access = customer_q;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < 128; i++)
                mem_q[i] <= 32'h00000000;
        end
        else if (do_wr && addr < `ADDR_MARG_DATA || do_wr && addr > `ADDR_MARG_CTRL)
            mem_q[addr] <= new_word;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ack_data_q <= 32'h00000000;
            ack_tgl_q <= 1'b0;
        end
        else if (do_rd)
        begin
            ack_data_q <= mask_field(cur_word, fs);
            ack_tgl_q <= ~ack_tgl_q;
        end
    end

    assign chk_ones = ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB] != `MODE_ZEROS;
    assign chk_zeros = ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB] != `MODE_ONES;
    // A weak bit fails only for the level being checked.
    assign word_bad = |((mem_q[{2'b00, ptr_q}] & margin_weak
        & {32{chk_ones}}) | (~mem_q[{2'b00, ptr_q}] & margin_weak
        & {32{chk_zeros}}));

    always_ff @(posedge clk)
    begin
        if (!nrst)
            ctrl_q <= 3'h0;
        else if (do_wr && addr == `ADDR_MARG_CTRL)
            ctrl_q <= new_word[2:0];
        else if (mstate_q == MS_RUN && ptr_q == `EE_WORDS_LAST)
            ctrl_q[`CTRL_START] <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            mstate_q <= MS_IDLE;
            ptr_q <= 5'h00;
        end
        else
        begin
            case (mstate_q)
                MS_IDLE:
                begin
                    ptr_q <= 5'h00;
                    if (do_wr && addr == `ADDR_MARG_CTRL
                        && new_word[`CTRL_START])
                        mstate_q <= MS_RUN;
                end
                MS_RUN:
                begin
                    ptr_q <= ptr_q + 5'h01;
                    if (ptr_q == `EE_WORDS_LAST)
                        mstate_q <= MS_IDLE;
                end
                default: mstate_q <= MS_IDLE;
            endcase
        end
    end

    assign margin_addr = ptr_q;
    assign margin_state = mstate_q;

    // Failures only show in the result words, never on an output.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            done_q <= 1'b0;
            fail_q <= 1'b0;
            first_addr_q <= 5'h00;
            fail_cnt_q <= 6'h00;
            mdata_q <= 26'h0000000;
        end
        else if (mstate_q == MS_IDLE && do_wr && addr == `ADDR_MARG_CTRL
            && new_word[`CTRL_START])
        begin
            done_q <= 1'b0;
            fail_q <= 1'b0;
            first_addr_q <= 5'h00;
            fail_cnt_q <= 6'h00;
            mdata_q <= 26'h0000000;
        end
        else if (mstate_q == MS_RUN)
        begin
            if (ptr_q == `EE_WORDS_LAST)
                done_q <= 1'b1;
            if (word_bad)
            begin
                fail_q <= 1'b1;
                fail_cnt_q <= fail_cnt_q + 6'h01;
                if (!fail_q)
                begin
                    first_addr_q <= ptr_q;
                    mdata_q <= mem_q[{2'b00, ptr_q}][25:0];
                end
            end
        end
    end
endmodule // serial_memory_access_guard

// file: verification/guard_checker_properties.sv
// Port-level assertions for the serial memory access guard.
`timescale 1ns/1ps
module guard_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic link_clk,
    input wire logic link_frame,
    input wire logic link_dout,
    input wire logic link_doe,
    input wire logic [4:0] margin_addr,
    input wire logic customer_access,
    input wire guard_pkg::margin_state_t margin_state
);
    import guard_pkg::*;
    logic [5:0] doe_cnt_q;
    logic [6:0] run_cnt_q;
    always_ff @(posedge link_clk)
    begin
        if (!nrst || !link_doe)
            doe_cnt_q <= 6'h00;
        else
            doe_cnt_q <= doe_cnt_q + 6'h01;
    end
    always_ff @(posedge clk)
    begin
        if (!nrst || margin_state != MS_RUN)
            run_cnt_q <= 7'h00;
        else
            run_cnt_q <= run_cnt_q + 7'h01;
    end
    property p_doe_in_frame;
        @(posedge link_clk) disable iff (!nrst) link_doe |-> link_frame;
    endproperty
    a_doe_in_frame: assert property (p_doe_in_frame)
        else $error("link driven outside a frame");
    property p_ack_len;
        @(posedge link_clk) disable iff (!nrst)
        $fell(link_doe) |-> doe_cnt_q == 6'h25;
    endproperty
    a_ack_len: assert property (p_ack_len)
        else $error("acknowledge length wrong");
    property p_ack_sync;
        @(posedge link_clk) disable iff (!nrst)
        $rose(link_doe) |-> !link_dout ##1 !link_dout;
    endproperty
    a_ack_sync: assert property (p_ack_sync)
        else $error("acknowledge sync bits not zero");
    property p_cust_sticky;
        @(posedge clk) disable iff (!nrst)
        customer_access |=> customer_access;
    endproperty
    a_cust_sticky: assert property (p_cust_sticky)
        else $error("customer access dropped");
    property p_reset_idle;
        @(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> !customer_access && margin_state == MS_IDLE;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("outputs not cleared by reset");
    property p_margin_cust;
        @(posedge clk) disable iff (!nrst)
        margin_state == MS_RUN |-> customer_access;
    endproperty
    a_margin_cust: assert property (p_margin_cust)
        else $error("margin run without customer access");
    property p_margin_len;
        @(posedge clk) disable iff (!nrst)
        $fell(margin_state == MS_RUN) |-> run_cnt_q == 7'h20;
    endproperty
    a_margin_len: assert property (p_margin_len)
        else $error("margin run length wrong");
    property p_margin_step;
        @(posedge clk) disable iff (!nrst)
        margin_state == MS_RUN && $past(margin_state) == MS_RUN
        |-> margin_addr == $past(margin_addr) + 5'h01;
    endproperty
    a_margin_step: assert property (p_margin_step)
        else $error("margin word index skipped");
    property p_margin_quiet;
        @(posedge clk) disable iff (!nrst)
        $fell(margin_state == MS_RUN) |=> $stable(customer_access);
    endproperty
    a_margin_quiet: assert property (p_margin_quiet)
        else $error("margin end disturbed access state");
    c_unlock: cover property (@(posedge clk) $rose(customer_access));
    c_margin: cover property (@(posedge clk) $fell(margin_state == MS_RUN));
    c_ack: cover property (@(posedge link_clk) $fell(link_doe));
endmodule // guard_checker
bind serial_memory_access_guard guard_checker i_chk (
    .clk(clk),
    .nrst(nrst),
    .link_clk(link_clk),
    .link_frame(link_frame),
    .link_dout(link_dout),
    .link_doe(link_doe),
    .margin_addr(margin_addr),
    .customer_access(customer_access),
    .margin_state(margin_state)
);

// file: verification/prog_controller_model.sv
// Behavioural programming controller on the far side of the link.
`timescale 1ns/1ps
module prog_controller_model (
    input wire logic nrst,
    input wire logic link_dout,
    input wire logic link_doe,
    output logic link_clk,
    output logic link_frame,
    output logic link_din
);
    logic bit_clk;
    logic run;
    // The bit clock only reaches the pin during frames, the pulse before each frame, and reset.
    assign link_clk = bit_clk & (run | ~nrst);
    initial
    begin
        run = 1'b0;
        link_frame = 1'b0;
        link_din = 1'b0;
        bit_clk = 1'b0;
        #1;
        forever
        begin
            bit_clk = ~bit_clk;
            #6;
        end
    end
    function automatic logic [2:0] crc_next(input logic [2:0] c,
        input logic b);
        logic f;
        f = c[2] ^ b;
        return {c[1], c[0] ^ f, f};
    endfunction
    task automatic pulse(input int n);
        @(negedge bit_clk);
        run = 1'b1;
        repeat (n) @(negedge bit_clk);
        run = 1'b0;
    endtask
    task automatic send(input logic rw, input logic [1:0] fs,
        input logic [6:0] a, input logic [31:0] d, input logic bad);
        logic [50:0] bits;
        logic [2:0] crc;
        int n;
        n = rw ? 19 : 51;
        bits = {2'b00, rw, 4'h0, fs, a, rw ? 35'h0 : {d, 3'h0}};
        crc = 3'h7;
        for (int i = 2; i < n - 3; i++)
            crc = crc_next(crc, bits[50 - i]);
        if (bad)
            crc = ~crc;
        for (int i = 0; i < 3; i++)
            bits[50 - (n - 3) - i] = crc[2 - i];
        pulse(4);
        @(negedge bit_clk);
        link_frame = 1'b1;
        run = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            link_din = bits[50 - i];
            @(negedge bit_clk);
        end
        link_frame = 1'b0;
        run = 1'b0;
        link_din = ~link_din;
    endtask
    task automatic ack_slot(output logic [31:0] d, output logic ok,
        output logic act);
        logic [37:0] seen;
        logic [37:0] drv;
        logic [2:0] crc;
        pulse(4);
        @(negedge bit_clk);
        link_frame = 1'b1;
        run = 1'b1;
        for (int i = 0; i < 38; i++)
        begin
            @(negedge bit_clk);
            link_din = ~link_din;
            seen[37 - i] = link_dout;
            drv[37 - i] = link_doe;
        end
        link_frame = 1'b0;
        run = 1'b0;
        crc = 3'h7;
        for (int i = 35; i > 3; i--)
            crc = crc_next(crc, seen[i]);
        d = seen[35:4];
        ok = seen[37:36] == 2'b00 && seen[3:1] == crc && &drv[37:1];
        act = |drv;
    endtask
endmodule // prog_controller_model

// file: verification/serial_memory_access_guard_tb.sv
// Self-checking bench for the serial memory access guard.
`timescale 1ns/1ps
`define CHECK(nm, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("BAD %s expected %h seen %h", nm, exp, got); \
        end \
    end
module serial_memory_access_guard_tb;
    import guard_pkg::*;
    localparam logic [31:0] ACC = 32'h00000FA0;
    logic clk, nrst, link_clk, link_frame, link_din, link_dout, link_doe;
    logic [4:0] margin_addr;
    logic [31:0] margin_weak;
    logic customer_access;
    margin_state_t margin_state;
    int checks_done = 0;
    int miscompares = 0;
    int cycles = 0;
    // One weak zero-level bit in word 5 fails every margin mode except ones.
    assign margin_weak = (margin_addr == 5'h05) ? 32'h8 : 32'h0;
    serial_memory_access_guard #(
        .ACC_CYCLES(ACC)
    ) i_dut (
        .clk(clk),
        .nrst(nrst),
        .link_clk(link_clk),
        .link_frame(link_frame),
        .link_din(link_din),
        .link_dout(link_dout),
        .link_doe(link_doe),
        .margin_addr(margin_addr),
        .margin_weak(margin_weak),
        .customer_access(customer_access),
        .margin_state(margin_state)
    );
    prog_controller_model i_ctrl (
        .nrst(nrst),
        .link_dout(link_dout),
        .link_doe(link_doe),
        .link_clk(link_clk),
        .link_frame(link_frame),
        .link_din(link_din)
    );
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic wr(input logic [1:0] fs, input logic [6:0] a,
        input logic [31:0] d);
        i_ctrl.send(1'b0, fs, a, d, 1'b0);
    endtask
    task automatic rd(input logic [1:0] fs, input logic [6:0] a,
        input logic [31:0] exp);
        logic [31:0] d;
        logic ok, act;
        i_ctrl.send(1'b1, fs, a, 32'h0, 1'b0);
        i_ctrl.ack_slot(d, ok, act);
        `CHECK("ack_ok", 1'b1, ok)
        `CHECK("rdata", exp, d)
    endtask
    task automatic unlock(input logic bad, input logic exp);
        i_ctrl.send(1'b0, 2'h0, 7'h79, 32'hC41D3432, bad);
        repeat (40) @(posedge clk);
        #1;
        `CHECK("customer_access", exp, customer_access)
    endtask
    task automatic fresh();
        nrst = 1'b0;
        repeat (6) @(posedge clk);
        repeat (3) @(posedge link_clk);
        @(posedge clk);
        #1;
        nrst = 1'b1;
        `CHECK("margin_state", MS_IDLE, margin_state)
        `CHECK("customer_access", 1'b0, customer_access)
        `CHECK("link_doe", 1'b0, link_doe)
    endtask
    task automatic t_window();
        fresh();
        unlock(1'b1, 1'b0);
        repeat (ACC + 100) @(posedge clk);
        unlock(1'b0, 1'b0);
        wr(2'h0, 7'h44, 32'h1);
        rd(2'h0, 7'h44, 32'h0);
        $display("test window finished");
    endtask
    task automatic t_fields();
        fresh();
        unlock(1'b0, 1'b1);
        wr(2'h0, 7'h44, 32'hA5A5A5A5);
        rd(2'h0, 7'h44, 32'hA5A5A5A5);
        wr(2'h1, 7'h44, 32'h00000123);
        rd(2'h1, 7'h44, 32'h00000123);
        rd(2'h2, 7'h44, 32'h01A5A000);
        wr(2'h2, 7'h44, 32'h0);
        wr(2'h3, 7'h44, 32'hFFFFFFFF);
        i_ctrl.send(1'b0, 2'h0, 7'h44, 32'h0, 1'b1);
        rd(2'h0, 7'h44, 32'hA4000123);
        wr(2'h0, 7'h03, 32'h1234);
        rd(2'h0, 7'h03, 32'h0);
        wr(2'h0, 7'h41, 32'h55);
        rd(2'h0, 7'h41, 32'h0);
        $display("test fields finished");
    endtask
    task automatic t_margin();
        logic fail;
        int n;
        fresh();
        unlock(1'b0, 1'b1);
        for (int m = 0; m < 4; m++)
        begin
            fail = (m != 1);
            wr(2'h0, 7'h43, 32'(m * 2 + 1));
            n = 0;
            while (margin_state !== MS_RUN && n < 100)
            begin
                @(posedge clk);
                #1;
                n++;
            end
            `CHECK("margin_state", MS_RUN, margin_state)
            repeat (40) @(posedge clk);
            #1;
            `CHECK("margin_state", MS_IDLE, margin_state)
            rd(2'h0, 7'h42, fail ? 32'h12E : 32'h2);
            rd(2'h0, 7'h43, 32'(m * 2));
            if (fail)
                rd(2'h0, 7'h41, 32'h0);
            `CHECK("customer_access", 1'b1, customer_access)
        end
        $display("test margin finished");
    endtask
    task automatic t_locks();
        logic [2:0] full [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
        fresh();
        unlock(1'b0, 1'b1);
        foreach (full[i])
        begin
            wr(2'h1, 7'h1E, {29'h0, full[i]});
            wr(2'h0, 7'h10, {29'h20, full[i]});
            rd(2'h0, 7'h10, {29'h20, full[i]});
        end
        wr(2'h1, 7'h1E, 32'h3);
        wr(2'h0, 7'h10, 32'h99);
        rd(2'h0, 7'h10, 32'h107);
        wr(2'h0, 7'h45, 32'h99);
        rd(2'h0, 7'h45, 32'h99);
        $display("test locks finished");
    endtask
    task automatic t_lock_hard(input logic [2:0] lk);
        logic [31:0] d;
        logic ok, act;
        fresh();
        unlock(1'b0, 1'b1);
        wr(2'h1, 7'h1E, {29'h0, lk});
        wr(2'h0, 7'h45, 32'h55);
        if (lk == 3'h6)
        begin
            rd(2'h0, 7'h1E, 32'h6);
            rd(2'h0, 7'h45, 32'h0);
        end
        else
        begin
            i_ctrl.send(1'b1, 2'h0, 7'h1E, 32'h0, 1'b0);
            i_ctrl.ack_slot(d, ok, act);
            `CHECK("no_ack", 1'b0, act)
        end
        $display("test hard lock %0d finished", lk);
    endtask
    initial
    begin
        nrst = 1'b0;
        t_window();
        t_fields();
        t_margin();
        t_locks();
        t_lock_hard(3'h6);
        t_lock_hard(3'h5);
        print_verdict();
    end
endmodule // serial_memory_access_guard_tb
